// ===== design/ssr_consts.vh
// Constants for the sensor configuration and status register block
`ifndef SSR_CONSTS_VH
`define SSR_CONSTS_VH
`define SSR_BIT_RES        0
`define SSR_BIT_NORELOAD   1
`define SSR_BIT_HEATER     2
`define SSR_BIT_TEST       3
`define SSR_BIT_LOWSUPPLY  6
`define SSR_RESET_VAL      8'h00
`define SSR_WR_MASK        8'h07
`define SSR_CMD_READ       5'h07
`define SSR_CMD_WRITE      5'h06
`define SSR_CMD_SOFTRESET  5'h1E
`define SSR_CMD_MEAS_TEMP  5'h03
`define SSR_CMD_MEAS_HUM   5'h05
`define SSR_ADDR           3'h0
`define SSR_IFRESET_CLKS   4'h9
`define SSR_SOFTRESET_MS   11
`define SSR_CLK_HZ         10000000
`endif

// ===== design/ssr_status_reg.v
// Sensor configuration and status register with its two-wire serial front end
//
// Behaviour
// - Bit 0 set: humidity 8 bit, temperature 12 bit; clear: 12 and 14 bit.
// - Resolution bit resets to 0, giving full precision conversions.
// - Bit 6 read-only low-supply flag, updated only when a measurement completes.
// - Bit 2 heater enable, resets off, set by a register write.
// - Bits 7, 5, 4 read zero; bit 3 resets zero, host writes zero.
// - Command 00111 reads all eight register bits, 00110 writes bits 2 to 0 only.
// - Soft reset 11110 resets interface and bits 2 to 0, bit 6 kept; 11 ms busy after.
// - Nine or more clocks with data high reset the interface only.
`timescale 1ns/1ps
`include "ssr_consts.vh"
module ssr_status_reg #(
  parameter integer SOFT_RESET_CYCLES = `SSR_SOFTRESET_MS * (`SSR_CLK_HZ / 1000)
) (
  // Clock, reset, enable
  input  wire       ref_clk,
  input  wire       resetn,
  input  wire       clkEn,
  // Serial link pins
  input  wire       sck,
  input  wire       dataIn,
  output wire       dataOut,
  output wire       dataOe,
  // Measurement core
  input  wire       measDone,
  input  wire       lowSupply,
  output reg        measStart,
  output reg        measIsHum,
  output wire [3:0] humBits,
  output wire [3:0] tempBits,
  output wire       heaterOn,
  output wire       otpReload,
  output wire       busy
);

  // ****************************************************
  // Synchronisers and edge detection
  // ****************************************************
  reg [1:0] sckSync_q;
  reg [1:0] datSync_q;
  reg       sckOld_q;
  reg       datOld_q;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sckSync_q <= 2'h0;
      datSync_q <= 2'h3;
      sckOld_q  <= 1'b0;
      datOld_q  <= 1'b1;
    end else if (clkEn) begin
      sckSync_q <= {sckSync_q[0], sck};
      datSync_q <= {datSync_q[0], dataIn};
      sckOld_q  <= sckSync_q[1];
      datOld_q  <= datSync_q[1];
    end
  end
  wire sckS   = sckSync_q[1];
  wire datS   = datSync_q[1];
  wire sckRise = sckS & ~sckOld_q;
  wire sckFall = ~sckS & sckOld_q;
  // Start sequence begins with data falling while clock is high
  wire startSeen = sckS & sckOld_q & datOld_q & ~datS;
  // It ends with data rising while clock is high; its second clock pulse carries no bit
  wire startDone = sckS & sckOld_q & ~datOld_q & datS;

  // ****************************************************
  // Frame state machine
  // ****************************************************
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_CMD  = 3'h1;
  localparam [2:0] ST_ACK  = 3'h2;
  localparam [2:0] ST_WR   = 3'h3;
  localparam [2:0] ST_WACK = 3'h4;
  localparam [2:0] ST_RD   = 3'h5;
  localparam [2:0] ST_RACK = 3'h6;
  localparam [2:0] ST_START = 3'h7;

  reg [2:0]  state_q;
  reg [3:0]  bitCnt_q;
  reg [7:0]  shift_q;
  reg [7:0]  ctrl_q;
  reg        lowSup_q;
  reg        drive_q;
  reg [3:0]  highCnt_q;
  reg [23:0] busyCnt_q;
  reg [4:0]  cmd_q;

  function isValidCmd;
    input [7:0] b;
    begin
      isValidCmd = (b[7:5] == `SSR_ADDR) &&
        (b[4:0] == `SSR_CMD_READ || b[4:0] == `SSR_CMD_WRITE ||
         b[4:0] == `SSR_CMD_SOFTRESET || b[4:0] == `SSR_CMD_MEAS_TEMP ||
         b[4:0] == `SSR_CMD_MEAS_HUM);
    end
  endfunction

  // Register image as read by the host
  wire [7:0] regImage = {1'b0, lowSup_q, 3'h0, ctrl_q[2:0]};

  assign dataOut  = 1'b0;
  assign dataOe   = drive_q;
  assign heaterOn  = ctrl_q[`SSR_BIT_HEATER];
  assign otpReload = ~ctrl_q[`SSR_BIT_NORELOAD];
  assign humBits   = ctrl_q[`SSR_BIT_RES] ? 4'h8 : 4'hC;
  assign tempBits  = ctrl_q[`SSR_BIT_RES] ? 4'hC : 4'hE;
  assign busy      = (busyCnt_q != 24'h0);

  // Interface reset counter: clock pulses while data stays high
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      highCnt_q <= 4'h0;
    else if (clkEn) begin
      if (!datS)
        highCnt_q <= 4'h0;
      else if (sckRise && highCnt_q != `SSR_IFRESET_CLKS)
        highCnt_q <= highCnt_q + 4'h1;
    end
  end
  // Data falling drops it at once, so a start right after the sequence is not lost
  wire ifReset = (highCnt_q == `SSR_IFRESET_CLKS) && datS;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q   <= ST_IDLE;
      bitCnt_q  <= 4'h0;
      shift_q   <= 8'h00;
      ctrl_q    <= `SSR_RESET_VAL;
      lowSup_q  <= 1'b0;
      drive_q   <= 1'b0;
      busyCnt_q <= 24'h0;
      cmd_q     <= 5'h00;
      measStart <= 1'b0;
      measIsHum <= 1'b0;
    end else if (clkEn) begin
      measStart <= 1'b0;
      if (busyCnt_q != 24'h0)
        busyCnt_q <= busyCnt_q - 24'h1;
      // Only a finished measurement refreshes the supply flag
      if (measDone)
        lowSup_q <= lowSupply;
      if (ifReset) begin
        // Register contents deliberately untouched
        state_q <= ST_IDLE;
        drive_q <= 1'b0;
      end else if (startSeen && !busy) begin
        state_q  <= ST_START;
        bitCnt_q <= 4'h0;
        drive_q  <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            drive_q <= 1'b0;
          end
          ST_START: begin
            // Counting starts only once the start pattern has finished
            if (startDone) begin
              state_q  <= ST_CMD;
              bitCnt_q <= 4'h0;
            end
          end
          ST_CMD: begin
            if (sckRise) begin
              shift_q  <= {shift_q[6:0], datS};
              bitCnt_q <= bitCnt_q + 4'h1;
            end else if (sckFall && bitCnt_q == 4'h8) begin
              if (isValidCmd(shift_q)) begin
                cmd_q   <= shift_q[4:0];
                drive_q <= 1'b1;
                state_q <= ST_ACK;
              end else
                state_q <= ST_IDLE;
            end
          end
          ST_ACK: begin
            if (sckFall) begin
              drive_q  <= 1'b0;
              bitCnt_q <= 4'h0;
              case (cmd_q)
                `SSR_CMD_WRITE: state_q <= ST_WR;
                `SSR_CMD_READ: begin
                  shift_q <= regImage;
                  drive_q <= ~regImage[7];
                  state_q <= ST_RD;
                end
                `SSR_CMD_SOFTRESET: begin
                  ctrl_q    <= `SSR_RESET_VAL;
                  busyCnt_q <= SOFT_RESET_CYCLES[23:0];
                  state_q   <= ST_IDLE;
                end
                default: begin
                  // Reload choice is visible to the core through otpReload
                  measStart <= 1'b1;
                  measIsHum <= (cmd_q == `SSR_CMD_MEAS_HUM);
                  state_q   <= ST_IDLE;
                end
              endcase
            end
          end
          ST_WR: begin
            if (sckRise) begin
              shift_q  <= {shift_q[6:0], datS};
              bitCnt_q <= bitCnt_q + 4'h1;
            end else if (sckFall && bitCnt_q == 4'h8) begin
              // Test bit and reserved bits are not stored
              ctrl_q  <= shift_q & `SSR_WR_MASK;
              drive_q <= 1'b1;
              state_q <= ST_WACK;
            end
          end
          ST_WACK: begin
            if (sckFall) begin
              drive_q <= 1'b0;
              state_q <= ST_IDLE;
            end
          end
          ST_RD: begin
            if (sckFall) begin
              if (bitCnt_q == 4'h7) begin
                drive_q <= 1'b0;
                state_q <= ST_RACK;
              end else begin
                shift_q  <= {shift_q[6:0], 1'b0};
                drive_q  <= ~shift_q[6];
                bitCnt_q <= bitCnt_q + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (sckFall)
              state_q <= ST_IDLE;
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

endmodule // ssr_status_reg

// ===== verif/ssr_status_reg_monitor.sv
// Port checker for the status register block
`timescale 1ns/1ps
module ssr_status_reg_monitor #(parameter integer SOFT_RESET_CYCLES = 110000) (
  // All ports of the block
  input wire       ref_clk, resetn, clkEn, sck, dataIn, dataOut, dataOe, measDone,
  input wire       lowSupply, measStart, measIsHum, heaterOn, otpReload, busy,
  input wire [3:0] humBits, tempBits
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  integer busyCnt;
  always @(posedge ref_clk or negedge resetn)
    if (!resetn) busyCnt <= 0;
    else busyCnt <= busy ? busyCnt + 1 : 0;
  AST_RES_PAIR: assert property ((humBits == 4'hC && tempBits == 4'hE) ||
    (humBits == 4'h8 && tempBits == 4'hC)) else $error("bad width pair");
  AST_RST_DEF: assert property ($rose(resetn) |-> humBits == 4'hC &&
    tempBits == 4'hE && !heaterOn && otpReload && !busy) else $error("bad defaults");
  AST_HEAT_ON: assert property ($rose(heaterOn) |-> !busy)
    else $error("heater on while busy");
  AST_OPEN_DRAIN: assert property (dataOut == 1'b0)
    else $error("data driven high");
  AST_BUSY_HOLD: assert property ($rose(busy) |-> busy[*8])
    else $error("busy too short");
  AST_SR_CLEAR: assert property ($rose(busy) |-> ##[0:3] (!heaterOn && otpReload &&
    humBits == 4'hC)) else $error("soft reset kept bits");
  AST_BUSY_MAX: assert property (busyCnt <= SOFT_RESET_CYCLES + 2)
    else $error("busy too long");
  AST_NO_ACK: assert property (busy && $past(busy, 8) |-> !$rose(dataOe))
    else $error("ack while busy");
  AST_MEAS_PULSE: assert property (measStart |=> !measStart && !busy)
    else $error("measure start not a single pulse");
endmodule // ssr_status_reg_monitor
bind ssr_status_reg ssr_status_reg_monitor #(.SOFT_RESET_CYCLES(SOFT_RESET_CYCLES)) i_mon (
  .ref_clk(ref_clk), .resetn(resetn), .clkEn(clkEn), .sck(sck), .dataIn(dataIn),
  .dataOut(dataOut), .dataOe(dataOe), .measDone(measDone), .lowSupply(lowSupply),
  .measStart(measStart), .measIsHum(measIsHum), .heaterOn(heaterOn),
  .otpReload(otpReload), .busy(busy), .humBits(humBits), .tempBits(tempBits));

// ===== verif/ssr_host.sv
// Host model on the two-wire link, data line pulled up
`timescale 1ns/1ps
module ssr_host (
  input  logic ref_clk, dataOe,
  output logic sck, dataIn
);
  logic low = 0;
  logic smp;
  assign dataIn = !(low | dataOe);
  initial sck = 0;
  // Sample just before each change so a read bit is taken while sck is high
  task automatic step(input int n, input logic s, input logic l);
    repeat (n) @(negedge ref_clk);
    smp = dataIn;
    sck = s;
    low = l;
  endtask
  task automatic bit1(input logic d); // 800 ns per bit
    step(2, 0, !d); step(2, 1, !d); step(4, 0, !d);
  endtask
  task automatic ifrst;
    repeat (10) bit1(1);
  endtask
  task automatic xfer(input logic [7:0] c, w, input logic wr, output logic [7:0] r,
                      output logic a);
    step(4, 1, 0); step(4, 1, 1); step(4, 0, 1); step(4, 1, 1); step(4, 1, 0); step(4, 0, 0);
    for (int i = 7; i >= 0; i--) bit1(c[i]);
    bit1(1);
    a = !smp;
    for (int i = 7; i >= 0; i--) begin
      bit1(wr ? w[i] : 1'b1);
      r[i] = smp;
    end
    bit1(1);
    if (wr) a &= !smp;
  endtask
endmodule // ssr_host

// ===== verif/testbench.sv
// Self-checking bench for the status register block
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 0, resetn = 0, clkEn = 1, measDone = 0, lowSupply = 0;
  logic sck, dataIn, dataOut, dataOe, measStart, measIsHum, heaterOn, otpReload, busy, a;
  logic [3:0] humBits, tempBits;
  logic [7:0] r, v;
  logic [7:0] measCnt = 8'h00;
  logic       measHum = 1'b0;
  logic [31:0] seed = 32'h742AE87B;
  int err_count = 0, cmp_count = 0;
  // Long soft-reset wait shortened so a start can land inside it
  ssr_status_reg #(.SOFT_RESET_CYCLES(200)) i_dut (.ref_clk(ref_clk), .resetn(resetn),
    .clkEn(clkEn), .sck(sck), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .measDone(measDone), .lowSupply(lowSupply), .measStart(measStart),
    .measIsHum(measIsHum), .humBits(humBits), .tempBits(tempBits), .heaterOn(heaterOn),
    .otpReload(otpReload), .busy(busy));
  ssr_host i_host (.ref_clk(ref_clk), .dataOe(dataOe), .sck(sck), .dataIn(dataIn));
  initial forever #50 ref_clk = ~ref_clk;
  // Count measurement start pulses and keep the kind of the last one
  always @(posedge ref_clk) begin
    if (measStart === 1'b1) begin
      measCnt <= measCnt + 8'h01;
      measHum <= measIsHum;
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13; x ^= x >> 17; x ^= x << 5;
    return x;
  endfunction
  function automatic logic [8:0] rdExp(input logic ls, input logic [7:0] c);
    return {1'b1, 1'b0, ls, 3'h0, c[2:0]};
  endfunction
  task automatic chk(input logic [8:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic outs(input logic [7:0] c);
    chk({heaterOn, otpReload, tempBits}, {c[2], !c[1], c[0] ? 4'hC : 4'hE});
    chk(humBits, c[0] ? 4'h8 : 4'hC);
  endtask
  task automatic rd(input logic ls, input logic [7:0] c);
    i_host.xfer(8'h07, 8'h00, 0, r, a);
    chk({a, r}, rdExp(ls, c));
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge ref_clk);
    err_count++;
    conclude;
  end
  initial begin
    repeat (10) @(negedge ref_clk);
    resetn = 1;
    repeat (4) @(negedge ref_clk);
    outs(8'h00);
    rd(0, 8'h00);
    $display("reset test done");
    // Reserved bits written high first, then random values
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      v = (i == 0) ? 8'hF7 : seed[7:0] & 8'hF7;
      i_host.xfer(8'h06, v, 1, r, a);
      chk(a, 1);
      rd(0, v);
      outs(v);
    end
    $display("write test done");
    lowSupply = 1;
    rd(0, v);
    measDone = 1;
    @(negedge ref_clk) measDone = 0;
    repeat (4) @(negedge ref_clk);
    lowSupply = 0;
    rd(1, v);
    i_host.ifrst;
    rd(1, v);
    $display("flag and interface reset done");
    i_host.xfer(8'h27, 8'h00, 0, r, a);
    chk({a, r}, 9'h0FF);
    i_host.xfer(8'h1E, 8'h00, 0, r, a);
    chk(a, 1);
    i_host.xfer(8'h07, 8'h00, 0, r, a);
    chk({a, r}, 9'h0FF);
    for (int k = 0; k < 400 && busy !== 1'b0; k++) @(negedge ref_clk);
    chk(busy, 0);
    i_host.xfer(8'h07, 8'h00, 0, r, a);
    chk({a, r & 8'hBF}, 9'h100);
    outs(8'h00);
    $display("soft reset test done");
    i_host.xfer(8'h05, 8'h00, 0, r, a);
    chk({a, measCnt}, 9'h101);
    chk({measHum, otpReload}, 2'h3);
    i_host.xfer(8'h06, 8'h02, 1, r, a);
    chk(a, 1);
    i_host.xfer(8'h03, 8'h00, 0, r, a);
    chk({a, measCnt}, 9'h102);
    chk({measHum, otpReload}, 2'h0);
    clkEn = 0;
    i_host.xfer(8'h06, 8'h04, 1, r, a);
    clkEn = 1;
    chk({a, heaterOn}, 2'h0);
    rd(1, 8'h02);
    $display("measure and enable test done");
    conclude;
  end
endmodule // testbench
